//--- logic/spicfg_pkg.sv
// package: register map, field layout, reset values and state of spicfg
package spicfg_pkg;

    // ******************************************************************
    // register byte addresses
    // ******************************************************************
    localparam logic [7:0] SPICFG_OFS_OPTION   = 8'h00;
    localparam logic [7:0] SPICFG_OFS_BITRATE  = 8'h04;
    localparam logic [7:0] SPICFG_OFS_FLAGS    = 8'h08;
    localparam logic [7:0] SPICFG_OFS_MODE     = 8'h0C;
    localparam logic [7:0] SPICFG_OFS_IRQ_STAT = 8'h10;
    localparam logic [7:0] SPICFG_OFS_IRQ_MASK = 8'h14;

    // ******************************************************************
    // field positions
    // ******************************************************************
    localparam int SPICFG_OPT_MFE    = 4; // mode_fault_enable
    localparam int SPICFG_OPT_SWOE   = 3; // single_wire_output_enable
    localparam int SPICFG_OPT_SIW    = 1; // stop_in_wait
    localparam int SPICFG_OPT_SWS    = 0; // single_wire_select
    localparam int SPICFG_BR_PRE_LSB = 4; // prescale_select 6:4
    localparam int SPICFG_BR_RATE_LSB = 0; // rate_divisor_select 2:0
    localparam int SPICFG_FLG_RXF    = 7;
    localparam int SPICFG_FLG_TXE    = 5;
    localparam int SPICFG_FLG_MODF   = 4;
    localparam int SPICFG_MODE_MASTER_SELECT  = 0; // master_select
    localparam int SPICFG_MODE_SELECT_OUTPUT_ENABLE  = 1; // select_output_enable
    localparam int SPICFG_EV_MODF    = 0; // event bits in irq regs
    localparam int SPICFG_EV_RXF     = 1;
    localparam int SPICFG_EV_TXE     = 2;

    // ******************************************************************
    // reset values
    // ******************************************************************
    localparam logic [7:0] SPICFG_RST_OPTION  = 8'h00;
    localparam logic [7:0] SPICFG_RST_BITRATE = 8'h00;
    localparam logic [1:0] SPICFG_RST_MODE    = 2'h0;
    localparam logic [2:0] SPICFG_RST_IRQ     = 3'h0;

    // pin steering role of the device
    typedef enum logic [1:0] {
        SPICFG_ROLE_SLAVE  = 2'b00,
        SPICFG_ROLE_GPIO   = 2'b01,
        SPICFG_ROLE_MFIN   = 2'b10,
        SPICFG_ROLE_SSOUT  = 2'b11
    } spicfg_ss_role_t;

    // one driven pin: value, enable and gpio release
    typedef struct packed {
        logic o;
        logic oe;
        logic release_gpio;
    } spicfg_pin_t;

    // whole state of the block
    typedef struct packed {
        logic            mfe, swoe, siw, sws;
        logic [2:0]      pre, rate;
        logic            master_select, select_output_enable;
        logic [2:0]      irq_stat, irq_mask;
        logic            modf, rxf_prev, txe_prev;
        logic [2:0]      pre_cnt;
        logic [7:0]      div_cnt;
        logic            bit_tick, clk_run, irq, rx_bit;
        spicfg_pin_t     mosi, miso, ss;
        spicfg_ss_role_t ss_role;
        logic [31:0]     prdata;
        logic            pready, pslverr;
    } spicfg_state_t;

endpackage : spicfg_pkg

//--- logic/spicfg_top.sv
// spi pin configuration, bit-rate generator and apb register file
//
// What this block does
// - slave: fault enable ignored, select is input
// - master, fault disabled: select pin released
// - master, fault enabled: select input or output
// - select output enable picks fault input/output
// - single wire: output enable drives shared pin
// - two wire: single-wire output enable ignored
// - single wire: master uses mosi, slave miso
// - two wire: separate receive and transmit pins
// - single wire: unused data pin released
// - stop in wait halts clocks in wait
// - bit-rate register accessible at any time
// - prescaler divides bus clock by field plus one
// - divider by two to field plus one
// - status holds three flags, others zero
// - status writes change nothing
`timescale 1ns/100ps
`default_nettype none

module spicfg_top (
    input  wire logic        mclk_in,
    input  wire logic        rst_b_in,
    // apb slave
    input  wire logic        psel_in,
    input  wire logic        penable_in,
    input  wire logic        pwrite_in,
    input  wire logic [7:0]  paddr_in,
    input  wire logic [31:0] pwdata_in,
    output logic      [31:0] prdata_out,
    output logic             pready_out,
    output logic             pslverr_out,
    output logic             irq_out,
    // neighbouring shifter and core
    input  wire logic        wait_mode_in,
    input  wire logic        tx_bit_in,
    input  wire logic        xfer_active_in,
    input  wire logic        rx_full_in,
    input  wire logic        tx_empty_in,
    input  wire logic        mode_fault_clear_in,
    output logic             rx_bit_out,
    output logic             bit_tick_out,
    output logic             clk_run_out,
    output logic             master_out,
    output logic             mode_fault_out,
    // serial pins
    input  wire logic        mosi_in,
    output logic             mosi_out,
    output logic             mosi_oe_out,
    output logic             mosi_gpio_out,
    input  wire logic        miso_in,
    output logic             miso_out,
    output logic             miso_oe_out,
    output logic             miso_gpio_out,
    input  wire logic        ss_b_in,
    output logic             ss_b_out,
    output logic             ss_oe_out,
    output logic             ss_gpio_out
);

    // ******************************************************************
    // helper functions
    // ******************************************************************

    // last count of the power-of-two divider for a rate field
    function automatic logic [7:0] spicfg_div_last(input logic [2:0] r);
        logic [8:0] full;
        // nine bits: rate seven must not wrap
        full = 9'h002 << r;
        spicfg_div_last = full[7:0] - 8'h01;
    endfunction : spicfg_div_last

    // pick the slave-select role from mode bits
    function automatic spicfg_pkg::spicfg_ss_role_t spicfg_role(
        input logic m, input logic f, input logic o);
        // slave first, then fault enable
        if (!m) begin
            spicfg_role = spicfg_pkg::SPICFG_ROLE_SLAVE;
        end else if (!f) begin
            spicfg_role = spicfg_pkg::SPICFG_ROLE_GPIO;
        end else if (!o) begin
            spicfg_role = spicfg_pkg::SPICFG_ROLE_MFIN;
        end else begin
            spicfg_role = spicfg_pkg::SPICFG_ROLE_SSOUT;
        end
    endfunction : spicfg_role

    // ******************************************************************
    // state
    // ******************************************************************
    spicfg_pkg::spicfg_state_t s_q;
    spicfg_pkg::spicfg_state_t s_d;

    // decoded strobes and events
    logic       apb_setup;
    logic       apb_write;
    logic [2:0] ev_set;
    logic       modf_ev;
    logic       run;
    logic       pre_wrap;

    // byte images for reads
    logic [7:0] rd_opt;
    logic [7:0] rd_br;
    logic [7:0] rd_flags;

    // bus phase decode
    assign apb_setup = psel_in && !penable_in;
    // a write lands as pready is sampled
    assign apb_write = psel_in && penable_in && s_q.pready && pwrite_in;

    // readback images of the byte registers
    assign rd_opt = {3'h0, s_q.mfe, s_q.swoe, 1'b0, s_q.siw, s_q.sws};
    assign rd_br  = {1'b0, s_q.pre, 1'b0, s_q.rate};
    assign rd_flags = {rx_full_in, 1'b0, tx_empty_in, s_q.modf,
                       4'h0};

    // fault only watched when the select pin is a fault input
    assign modf_ev = (s_q.ss_role == spicfg_pkg::SPICFG_ROLE_MFIN)
                     && !ss_b_in;

    // clocks stop only when asked to halt in wait
    assign run = !(s_q.siw && wait_mode_in);
    assign pre_wrap = run && (s_q.pre_cnt == s_q.pre);

    // ******************************************************************
    // next-state logic
    // ******************************************************************
    always_comb begin
        s_d = s_q;
        ev_set = 3'h0;

        // ---------------- register writes ----------------
        // bits above a field are ignored
        if (apb_write) begin
            case (paddr_in)
                spicfg_pkg::SPICFG_OFS_OPTION: begin
                    s_d.mfe  = pwdata_in[spicfg_pkg::SPICFG_OPT_MFE];
                    s_d.swoe = pwdata_in[spicfg_pkg::SPICFG_OPT_SWOE];
                    s_d.siw  = pwdata_in[spicfg_pkg::SPICFG_OPT_SIW];
                    s_d.sws  = pwdata_in[spicfg_pkg::SPICFG_OPT_SWS];
                end
                spicfg_pkg::SPICFG_OFS_BITRATE: begin
                    // no lock against a running transfer
                    s_d.pre  = pwdata_in[spicfg_pkg::SPICFG_BR_PRE_LSB +: 3];
                    s_d.rate = pwdata_in[spicfg_pkg::SPICFG_BR_RATE_LSB +: 3];
                end
                spicfg_pkg::SPICFG_OFS_MODE: begin
                    s_d.master_select = pwdata_in[spicfg_pkg::SPICFG_MODE_MASTER_SELECT];
                    s_d.select_output_enable = pwdata_in[spicfg_pkg::SPICFG_MODE_SELECT_OUTPUT_ENABLE];
                end
                spicfg_pkg::SPICFG_OFS_IRQ_STAT: begin
                    // w1c; an event wins below
                    s_d.irq_stat = s_q.irq_stat & ~pwdata_in[2:0];
                end
                spicfg_pkg::SPICFG_OFS_IRQ_MASK: begin
                    s_d.irq_mask = pwdata_in[2:0];
                end
                default: begin
                    // flag status writes fall here and are dropped
                end
            endcase
        end

        // ---------------- apb answer ----------------
        // zero wait states: pready rises in the access cycle
        s_d.pready  = apb_setup;
        // prdata holds outside the access
        s_d.pslverr = 1'b0;
        if (apb_setup) begin
            case (paddr_in)
                spicfg_pkg::SPICFG_OFS_OPTION:   s_d.prdata = {24'h0, rd_opt};
                spicfg_pkg::SPICFG_OFS_BITRATE:  s_d.prdata = {24'h0, rd_br};
                spicfg_pkg::SPICFG_OFS_FLAGS:    s_d.prdata = {24'h0, rd_flags};
                spicfg_pkg::SPICFG_OFS_MODE:
                    s_d.prdata = {30'h0, s_q.select_output_enable, s_q.master_select};
                spicfg_pkg::SPICFG_OFS_IRQ_STAT:
                    s_d.prdata = {29'h0, s_q.irq_stat};
                spicfg_pkg::SPICFG_OFS_IRQ_MASK:
                    s_d.prdata = {29'h0, s_q.irq_mask};
                default: begin
                    // unmapped: zero, error
                    s_d.prdata  = 32'h0;
                    s_d.pslverr = 1'b1;
                end
            endcase
        end

        // ---------------- mode fault flag ----------------
        // a fault in the clear cycle survives the clear
        if (mode_fault_clear_in) begin
            s_d.modf = 1'b0;
        end
        if (modf_ev) begin
            s_d.modf = 1'b1;
        end

        // ---------------- events and interrupt ----------------
        // buffer level rises become events
        s_d.rxf_prev = rx_full_in;
        s_d.txe_prev = tx_empty_in;
        ev_set[spicfg_pkg::SPICFG_EV_MODF] = modf_ev && !s_q.modf;
        ev_set[spicfg_pkg::SPICFG_EV_RXF]  = rx_full_in && !s_q.rxf_prev;
        ev_set[spicfg_pkg::SPICFG_EV_TXE]  = tx_empty_in && !s_q.txe_prev;
        // set applied after the clear so it wins
        s_d.irq_stat = s_d.irq_stat | ev_set;
        s_d.irq = |(s_d.irq_stat & s_d.irq_mask);

        // ---------------- bit-rate generator ----------------
        // master bit clock = bus / ((pre+1) * 2^(rate+1))
        // rates are tick pulses, not clocks
        s_d.bit_tick = 1'b0;
        s_d.clk_run  = run;
        // counters freeze while stopped
        if (!s_q.master_select) begin
            // slave takes its clock from the link; keep counters idle
            s_d.pre_cnt = 3'h0;
            s_d.div_cnt = 8'h00;
        end else if (run) begin
            if (pre_wrap) begin
                s_d.pre_cnt = 3'h0;
                if (s_q.div_cnt >= spicfg_div_last(s_q.rate)) begin
                    s_d.div_cnt  = 8'h00;
                    s_d.bit_tick = 1'b1;
                end else begin
                    s_d.div_cnt = s_q.div_cnt + 8'h01;
                end
            end else if (s_q.pre_cnt > s_q.pre) begin
                // field shrunk under a running count: restart cleanly
                s_d.pre_cnt = 3'h0;
            end else begin
                s_d.pre_cnt = s_q.pre_cnt + 3'h1;
            end
        end

        // ---------------- slave-select pin ----------------
        // registered role: pin is a cycle late
        s_d.ss_role = spicfg_role(s_q.master_select, s_q.mfe, s_q.select_output_enable);
        s_d.ss = '{o: 1'b1, oe: 1'b0, release_gpio: 1'b0};
        case (s_d.ss_role)
            spicfg_pkg::SPICFG_ROLE_SLAVE: begin
                s_d.ss.oe = 1'b0;
            end
            spicfg_pkg::SPICFG_ROLE_GPIO: begin
                s_d.ss.release_gpio = 1'b1;
            end
            spicfg_pkg::SPICFG_ROLE_MFIN: begin
                s_d.ss.oe = 1'b0;
            end
            spicfg_pkg::SPICFG_ROLE_SSOUT: begin
                s_d.ss.oe = 1'b1;
                // low for the whole transfer
                s_d.ss.o  = !xfer_active_in;
            end
            default: begin
                s_d.ss.release_gpio = 1'b1;
            end
        endcase

        // ---------------- data pins ----------------
        // data pins lag mode bits a cycle
        s_d.mosi = '{o: tx_bit_in, oe: 1'b0, release_gpio: 1'b0};
        s_d.miso = '{o: tx_bit_in, oe: 1'b0, release_gpio: 1'b0};
        if (!s_q.sws) begin
            // two wire; the single-wire enable is not looked at
            if (s_q.master_select) begin
                s_d.mosi.oe = 1'b1;
                s_d.rx_bit  = miso_in;
            end else begin
                s_d.miso.oe = !ss_b_in;
                s_d.rx_bit  = mosi_in;
            end
        end else if (s_q.master_select) begin
            s_d.mosi.oe = s_q.swoe;
            s_d.rx_bit  = mosi_in;
            s_d.miso.release_gpio = 1'b1;
        end else begin
            // slave drives only while selected, avoiding contention
            s_d.miso.oe = s_q.swoe && !ss_b_in;
            s_d.rx_bit  = miso_in;
            s_d.mosi.release_gpio = 1'b1;
        end
    end

    // ******************************************************************
    // state register
    // ******************************************************************
    always_ff @(posedge mclk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            s_q          <= '0;
            s_q.mfe      <= spicfg_pkg::SPICFG_RST_OPTION[spicfg_pkg::SPICFG_OPT_MFE];
            s_q.swoe     <= spicfg_pkg::SPICFG_RST_OPTION[spicfg_pkg::SPICFG_OPT_SWOE];
            s_q.siw      <= spicfg_pkg::SPICFG_RST_OPTION[spicfg_pkg::SPICFG_OPT_SIW];
            s_q.sws      <= spicfg_pkg::SPICFG_RST_OPTION[spicfg_pkg::SPICFG_OPT_SWS];
            s_q.pre      <= spicfg_pkg::SPICFG_RST_BITRATE[6:4];
            s_q.rate     <= spicfg_pkg::SPICFG_RST_BITRATE[2:0];
            s_q.master_select     <= spicfg_pkg::SPICFG_RST_MODE[0];
            s_q.select_output_enable     <= spicfg_pkg::SPICFG_RST_MODE[1];

            // interrupt and edge state
            s_q.irq_stat <= spicfg_pkg::SPICFG_RST_IRQ;
            s_q.irq_mask <= spicfg_pkg::SPICFG_RST_IRQ;
            // tx buffer idles empty: no false edge
            s_q.txe_prev <= 1'b1;
            s_q.clk_run  <= 1'b1;
            s_q.ss.o     <= 1'b1;
            s_q.ss_role  <= spicfg_pkg::SPICFG_ROLE_SLAVE;
        end else begin
            s_q <= s_d;
        end
    end

    // ******************************************************************
    // outputs, all straight from the state register
    // ******************************************************************
    assign prdata_out     = s_q.prdata;
    assign pready_out     = s_q.pready;
    assign pslverr_out    = s_q.pslverr;
    assign irq_out        = s_q.irq;

    // to the shifter and core
    assign rx_bit_out     = s_q.rx_bit;
    assign bit_tick_out   = s_q.bit_tick;
    assign clk_run_out    = s_q.clk_run;
    assign master_out     = s_q.master_select;
    assign mode_fault_out = s_q.modf;

    // serial pins
    assign mosi_out       = s_q.mosi.o;
    assign mosi_oe_out    = s_q.mosi.oe;
    assign mosi_gpio_out  = s_q.mosi.release_gpio;
    assign miso_out       = s_q.miso.o;
    assign miso_oe_out    = s_q.miso.oe;
    assign miso_gpio_out  = s_q.miso.release_gpio;
    assign ss_b_out       = s_q.ss.o;
    assign ss_oe_out      = s_q.ss.oe;
    assign ss_gpio_out    = s_q.ss.release_gpio;

endmodule : spicfg_top

`default_nettype wire

//--- sim/spicfg_assertions.sv
// concurrent checks on the spi configuration block ports
`timescale 1ns/100ps
`default_nettype none
module spicfg_checker (
    input  wire logic        mclk_in,
    input  wire logic        rst_b_in,
    input  wire logic        psel_in,
    input  wire logic        penable_in,
    input  wire logic        pwrite_in,
    input  wire logic [7:0]  paddr_in,
    input  wire logic [31:0] prdata_out,
    input  wire logic        pready_out,
    input  wire logic        xfer_active_in,
    input  wire logic        wait_mode_in,
    input  wire logic        master_out,
    input  wire logic        bit_tick_out,
    input  wire logic        clk_run_out,
    input  wire logic        mosi_oe_out,
    input  wire logic        mosi_gpio_out,
    input  wire logic        miso_oe_out,
    input  wire logic        miso_gpio_out,
    input  wire logic        ss_b_out,
    input  wire logic        ss_oe_out,
    input  wire logic        ss_gpio_out
);
    // one domain, so clock and reset are given once
    default clocking cb @(posedge mclk_in); endclocking
    default disable iff (!rst_b_in);
    opt_zero_a: assert property (
        pready_out && !pwrite_in && paddr_in == spicfg_pkg::SPICFG_OFS_OPTION
        |-> prdata_out[7:5] == 3'h0 && !prdata_out[2])
        else $error("option spare bits read nonzero");
    flag_zero_a: assert property (
        pready_out && !pwrite_in && paddr_in == spicfg_pkg::SPICFG_OFS_FLAGS
        |-> !prdata_out[6] && prdata_out[3:0] == 4'h0)
        else $error("flag spare bits read nonzero");
    slave_ss_a: assert property (
        !$past(master_out) |-> !ss_oe_out && !ss_gpio_out)
        else $error("slave select pin not an input");
    mosi_rel_a: assert property (
        mosi_gpio_out |-> !mosi_oe_out && !$past(master_out))
        else $error("released mosi pin still driven");
    miso_rel_a: assert property (
        miso_gpio_out |-> !miso_oe_out && $past(master_out))
        else $error("released miso pin still driven");
    ss_auto_a: assert property (
        ss_oe_out |-> $past(master_out) && ss_b_out == !$past(xfer_active_in))
        else $error("automatic select output wrong");
    run_wait_a: assert property (
        !clk_run_out |-> $past(wait_mode_in))
        else $error("clocks stopped outside wait");
    tick_slave_a: assert property (
        !$past(master_out) |-> !bit_tick_out)
        else $error("bit tick in slave mode");
    apb_ready_a: assert property (
        psel_in && !penable_in |-> !pready_out ##1 pready_out ##1 !pready_out)
        else $error("ready not one cycle after setup");
endmodule : spicfg_checker
bind spicfg_top spicfg_checker chk_i (.*);
`default_nettype wire

//--- sim/spicfg_far_model.sv
// far-side spi device model on the serial pins
`timescale 1ns/100ps
`default_nettype none
module spicfg_far_model (
    input  wire logic clk_in,
    input  wire logic sel_b_in,
    input  wire logic dev_mosi_in,
    input  wire logic dev_mosi_oe_in,
    input  wire logic dev_miso_in,
    input  wire logic dev_miso_oe_in,
    input  wire logic dev_ss_in,
    input  wire logic dev_ss_oe_in,
    output logic      mosi_line_out,
    output logic      miso_line_out,
    output logic      ss_line_out
);
    logic tog_q = 1'b0;
    // undriven data lines wander so a stale level is never trusted
    always_ff @(posedge clk_in) tog_q <= ~tog_q;
    // device driver wins where enabled, else the far side pattern
    assign mosi_line_out = dev_mosi_oe_in ? dev_mosi_in : tog_q;
    assign miso_line_out = dev_miso_oe_in ? dev_miso_in : ~tog_q;
    // select has a pull-up; the far master pulls it low to select
    assign ss_line_out = dev_ss_oe_in ? dev_ss_in : sel_b_in;
endmodule : spicfg_far_model
`default_nettype wire

//--- sim/testbench.sv
// self-checking bench for the spi configuration block
`timescale 1ns/100ps
`default_nettype none
module testbench;
    localparam logic [7:0] A_OPT = spicfg_pkg::SPICFG_OFS_OPTION;
    localparam logic [7:0] A_BR  = spicfg_pkg::SPICFG_OFS_BITRATE;
    localparam logic [7:0] A_FLG = spicfg_pkg::SPICFG_OFS_FLAGS;
    localparam logic [7:0] A_MD  = spicfg_pkg::SPICFG_OFS_MODE;
    localparam logic [7:0] A_IS  = spicfg_pkg::SPICFG_OFS_IRQ_STAT;
    localparam logic [7:0] A_IM  = spicfg_pkg::SPICFG_OFS_IRQ_MASK;
    logic        mclk = 0, rst_b = 0, psel = 0, pen = 0, pwr = 0;
    logic [7:0]  paddr = 0;
    logic [31:0] pwd = 0, prd, rd;
    logic        prdy, perr, er, irq, wmode = 0, txb = 1, xfer = 1;
    logic        rxf = 0, txe = 0, mfclr = 0, sel_b = 1;
    logic        rxb, tick, run, master_select, mf, mo, moe, mg, so, soe, sg;
    logic        ssb, select_output_enable, ssg, mosi_w, miso_w, ss_w, mosi_p, miso_p;
    int          error_cnt = 0, n_compared = 0;
    spicfg_top uut (.mclk_in(mclk), .rst_b_in(rst_b), .psel_in(psel),
        .penable_in(pen), .pwrite_in(pwr), .paddr_in(paddr),
        .pwdata_in(pwd), .prdata_out(prd), .pready_out(prdy),
        .pslverr_out(perr), .irq_out(irq), .wait_mode_in(wmode),
        .tx_bit_in(txb), .xfer_active_in(xfer), .rx_full_in(rxf),
        .tx_empty_in(txe), .mode_fault_clear_in(mfclr), .rx_bit_out(rxb),
        .bit_tick_out(tick), .clk_run_out(run), .master_out(master_select),
        .mode_fault_out(mf), .mosi_in(mosi_w), .mosi_out(mo),
        .mosi_oe_out(moe), .mosi_gpio_out(mg), .miso_in(miso_w),
        .miso_out(so), .miso_oe_out(soe), .miso_gpio_out(sg),
        .ss_b_in(ss_w), .ss_b_out(ssb), .ss_oe_out(select_output_enable), .ss_gpio_out(ssg));
    spicfg_far_model far (.clk_in(mclk), .sel_b_in(sel_b),
        .dev_mosi_in(mo), .dev_mosi_oe_in(moe), .dev_miso_in(so),
        .dev_miso_oe_in(soe), .dev_ss_in(ssb), .dev_ss_oe_in(select_output_enable),
        .mosi_line_out(mosi_w), .miso_line_out(miso_w), .ss_line_out(ss_w));
    always #20 mclk = ~mclk;
    // line levels as the design sampled them at the last edge
    always @(posedge mclk) begin
        mosi_p <= mosi_w;
        miso_p <= miso_w;
    end
    // ******************************************************************
    // shared tasks
    // ******************************************************************
    task automatic chk(input string nm, input logic [31:0] e, g);
        n_compared++;
        if (g !== e) begin
            error_cnt++;
            $display("ERROR %s expected %h seen %h", nm, e, g);
        end
    endtask : chk
    task automatic cyc(input int n);
        repeat (n) @(posedge mclk);
        #1;
    endtask : cyc
    // apb transfer; waits for ready, no fixed latency assumed
    task automatic apb(input logic w, input logic [7:0] a,
                       input logic [31:0] d);
        int n;
        n = 0;
        @(posedge mclk);
        psel <= 1'b1;
        pwr <= w;
        paddr <= a;
        pwd <= d;
        @(posedge mclk);
        pen <= 1'b1;
        do begin
            @(posedge mclk);
            n++;
        end while (prdy !== 1'b1 && n < 50);
        rd = prd;
        er = perr;
        psel <= 1'b0;
        pen <= 1'b0;
        if (n >= 50) chk("pready", 1, 0);
    endtask : apb
    task automatic rdc(input string nm, input logic [7:0] a,
                       input logic [31:0] e);
        apb(1'b0, a, 32'h0);
        chk(nm, e, rd);
    endtask : rdc
    task automatic end_of_test();
        $display("compared %0d mismatches %0d", n_compared, error_cnt);
        if (error_cnt == 0 && n_compared > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask : end_of_test
    // ******************************************************************
    // scenarios
    // ******************************************************************
    task automatic t_regs();
        rdc("option reset", A_OPT, 32'h0);
        rdc("rate reset", A_BR, 32'h0);
        apb(1'b1, A_OPT, 32'hFFFF_FFFF);
        rdc("option spare", A_OPT, 32'h1B);
        apb(1'b1, A_BR, 32'hFF);
        rdc("rate fields", A_BR, 32'h77);
        rxf <= 1'b1;
        txe <= 1'b1;
        apb(1'b1, A_FLG, 32'hFF);
        rdc("flags", A_FLG, 32'hA0);
        apb(1'b0, 8'h3C, 32'h0);
        chk("unmapped err", 1, er);
        $display("register test done");
    endtask : t_regs
    // pin roles over master, slave, one and two wire settings
    task automatic t_pins();
        logic [7:0] op [8] = '{8'h00, 8'h19, 8'h11, 8'h08,
                               8'h01, 8'h09, 8'h10, 8'h10};
        logic [1:0] md [8] = '{0, 0, 0, 1, 1, 1, 3, 1};
        logic [5:0] ex [8] = '{6'h08, 6'h18, 6'h10, 6'h21,
                               6'h05, 6'h25, 6'h22, 6'h20};
        sel_b <= 1'b0;
        for (int i = 0; i < 8; i++) begin
            apb(1'b1, A_MD, {30'h0, md[i]});
            apb(1'b1, A_OPT, {24'h0, op[i]});
            txb <= i[0];
            cyc(2);
            chk("pin roles", ex[i], {moe, mg, soe, sg, select_output_enable, ssg});
            chk("master sel", md[i][0], master_select);
            if (ex[i][5]) chk("mosi data", i[0], mo);
            if (ex[i][3]) chk("miso data", i[0], so);
            chk("rx pin", md[i][0] ^ op[i][0] ? miso_p : mosi_p,
                rxb);
            if (ex[i][1]) begin
                chk("auto select", 0, ssb);
                @(posedge mclk);
                xfer <= 1'b0;
                cyc(2);
                chk("select idle", 1, ssb);
                @(posedge mclk);
                xfer <= 1'b1;
            end
        end
        chk("mode fault", 1, mf);
        $display("pin test done");
    endtask : t_pins
    task automatic t_rate();
        int n;
        apb(1'b1, A_OPT, 32'h0);
        for (int i = 0; i < 8; i++) begin
            apb(1'b1, A_BR, {25'h0, 3'(i), 1'b0, 3'(i)});
            for (int j = 0; j < 3; j++) begin
                n = 0;
                do begin
                    cyc(1);
                    n++;
                end while (tick !== 1'b1 && n < 3000);
            end
            chk("bit period", (i + 1) << (i + 1), n);
        end
        $display("rate test done");
    endtask : t_rate
    task automatic t_wait();
        int n;
        n = 0;
        apb(1'b1, A_BR, 32'h0);
        apb(1'b1, A_OPT, 32'h2);
        wmode <= 1'b1;
        cyc(3);
        chk("run in wait", 0, run);
        repeat (20) begin
            cyc(1);
            if (tick !== 1'b0) n++;
        end
        chk("ticks in wait", 0, n);
        apb(1'b1, A_OPT, 32'h0);
        cyc(2);
        chk("run no stop", 1, run);
        @(posedge mclk);
        wmode <= 1'b0;
        $display("wait test done");
    endtask : t_wait
    // interrupt raised, masked, unmasked and cleared
    task automatic t_irq();
        @(posedge mclk);
        sel_b <= 1'b1;
        rxf <= 1'b0;
        mfclr <= 1'b1;
        @(posedge mclk);
        mfclr <= 1'b0;
        apb(1'b1, A_IS, 32'h7);
        apb(1'b1, A_IM, 32'h0);
        cyc(2);
        chk("fault cleared", 0, mf);
        @(posedge mclk);
        rxf <= 1'b1;
        rdc("irq status", A_IS, 32'h2);
        chk("irq masked", 0, irq);
        apb(1'b1, A_IM, 32'h2);
        cyc(2);
        chk("irq raised", 1, irq);
        apb(1'b1, A_IS, 32'h2);
        cyc(2);
        chk("irq cleared", 0, irq);
        $display("interrupt test done");
    endtask : t_irq
    // ******************************************************************
    // main sequence and watchdog
    // ******************************************************************
    initial begin
        repeat (12) @(posedge mclk);
        rst_b <= 1'b1;
        t_regs();
        t_pins();
        t_rate();
        t_wait();
        t_irq();
        end_of_test();
    end
    // whole run is near 11000 cycles; allow about four times that
    initial begin
        #(40 * 45000);
        error_cnt++;
        end_of_test();
    end
endmodule : testbench
`default_nettype wire
